// >>> cct_timer_regs.svh
// What this block does
// - three interrupt enables gate capture, compare, overflow requests; every reset clears them
// - edge select bit, 1 rising and 0 falling capture edge, kept across ordinary resets, cleared by power-on
// - output level bit drives compare pin on each match; reset clears it
// - capture flag set per selected edge; cleared by status read then capture low read
// - compare flag set on match; cleared by status read then compare low access
// - overflow flag set on wrap to zero; cleared by status read then counter low read
// - counter pair readable; reading high first freezes low byte until it is read
// - writes to counter, alternate counter and capture pairs are ignored
// - alternate counter pair latches alike but its low read never clears overflow
// - selected capture edge copies the whole counter into the capture pair
// - reading capture high blocks capture updates, except the one presented at stop exit, until capture low is read
// - writing compare high suppresses matches until compare low is written
// - counter keeps running in wait and halt; enabled interrupt wakes the processor
// - edge in stop arms capture silently; interrupt exit presents it, reset drops it
// - counter advances once every four clocks through a fixed divide by four
// - compare checked every fourth clock; match drives output level onto pin
`ifndef CCT_TIMER_REGS_SVH
`define CCT_TIMER_REGS_SVH
`define CCT_IDX_CTRL    6'h12
`define CCT_IDX_STAT    6'h13
`define CCT_IDX_CAPH    6'h14
`define CCT_IDX_CAPL    6'h15
`define CCT_IDX_CMPH    6'h16
`define CCT_IDX_CMPL    6'h17
`define CCT_IDX_CNTH    6'h18
`define CCT_IDX_CNTL    6'h19
`define CCT_IDX_ALTH    6'h1A
`define CCT_IDX_ALTL    6'h1B
`define CCT_IDX_EVTS    6'h1C
`define CCT_IDX_EVTM    6'h1D
`define CCT_CTRL_CAPIE  7
`define CCT_CTRL_CMPIE  6
`define CCT_CTRL_OVFIE  5
`define CCT_CTRL_EDGE   1
`define CCT_CTRL_COMPARE_OUTPUT_LEVEL   0
`define CCT_STAT_LSB    5
`define CCT_EV_CAP      2
`define CCT_EV_CMP      1
`define CCT_EV_OVF      0
`define CCT_CNT_RESET   16'hFFFC
`define CCT_CNT_MAX     16'hFFFF
`define CCT_PRESCALE    2'h3
`endif

// >>> cct_pkg.sv
package cct_pkg;
  typedef logic [7:0]  cct_byte_t;
  typedef logic [15:0] cct_word_t;
  typedef logic [2:0]  cct_ev_t;

  function automatic logic cct_hit(input logic [7:0] addr, input logic [5:0] idx);
    return addr == {idx, 2'h0};
  endfunction : cct_hit
endpackage : cct_pkg

// >>> cct_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module cct_sync2 (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output var  logic dout
);
  logic meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'h0;
      dout   <= 1'h0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : cct_sync2
`default_nettype wire

// >>> cct_prescale.sv
`timescale 1ns/100ps
`default_nettype none
`include "cct_timer_regs.svh"
module cct_prescale
  import cct_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  output var  logic tick
);
  logic [1:0] div_q;
  logic [1:0] div_d;
  logic       tick_d;

  always_comb begin
    div_d  = div_q + 2'h1;
    tick_d = (div_q == `CCT_PRESCALE - 2'h1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 2'h0;
      tick  <= 1'h0;
    end else begin
      div_q <= div_d;
      tick  <= tick_d;
    end
  end
endmodule : cct_prescale
`default_nettype wire

// >>> cct_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "cct_timer_regs.svh"
module cct_timer
  import cct_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        capture_pin,
  output var  logic        compare_pin,
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  output var  logic        irq,
  output var  logic        wake
);
  logic      tick;
  logic      cap_s;
  // power-on clears what ordinary resets leave alone
  logic      rst_all_n;
  assign rst_all_n = presetn & por_n;

  cct_prescale u_pre (
    .pclk    (pclk),
    .presetn (rst_all_n),
    .tick    (tick)
  );

  cct_sync2 u_sync (
    .pclk    (pclk),
    .presetn (rst_all_n),
    .din     (capture_pin),
    .dout    (cap_s)
  );

  logic      cap_prev_q, cap_prev_d;
  cct_ev_t   en_q, en_d;
  logic      edge_q, edge_d;
  logic      compare_output_level_q, compare_output_level_d;
  cct_ev_t   flags_q, flags_d;
  cct_ev_t   arm_q, arm_d;
  cct_word_t cnt_q, cnt_d;
  cct_byte_t cnt_lat_q, cnt_lat_d;
  logic      cnt_hold_q, cnt_hold_d;
  cct_byte_t alt_lat_q, alt_lat_d;
  logic      alt_hold_q, alt_hold_d;
  cct_word_t cap_q, cap_d;
  logic      cap_inh_q, cap_inh_d;
  cct_word_t cmp_q, cmp_d;
  logic      cmp_inh_q, cmp_inh_d;
  logic      stop_q, stop_d;
  logic      stp_arm_q, stp_arm_d;
  cct_word_t stp_val_q, stp_val_d;
  logic      pin_d;
  cct_ev_t   evt_sts_q, evt_sts_d;
  cct_ev_t   evt_msk_q, evt_msk_d;
  logic      irq_d, wake_d;
  logic      pready_d, pslverr_d;
  logic [31:0] prdata_d;

  logic      rd_go, wr_done, acc, cap_edge, stop_exit, run;
  cct_ev_t   set_ev, clr_ev;
  cct_byte_t rval;
  logic      mapped;

  always_comb begin
    acc       = psel && penable && !pready;
    rd_go     = acc && !pwrite;
    wr_done   = psel && penable && pready && pwrite;
    cap_edge  = edge_q ? (cap_s && !cap_prev_q) : (!cap_s && cap_prev_q);
    stop_exit = stop_q && !stop_mode;
    run       = tick && !stop_mode;
    cap_prev_d = cap_s;
    stop_d     = stop_mode;

    // timer counter, fixed divide by four
    cnt_d = run ? cnt_q + 16'h1 : cnt_q;

    // event detection
    set_ev = 3'h0;
    set_ev[`CCT_EV_CAP] = (cap_edge && !stop_mode) || (stop_exit && stp_arm_q);
    set_ev[`CCT_EV_CMP] = run && !cmp_inh_q && (cnt_q == cmp_q);
    set_ev[`CCT_EV_OVF] = run && (cnt_q == `CCT_CNT_MAX);

    // capture data path
    cap_d     = cap_q;
    stp_arm_d = stp_arm_q;
    stp_val_d = stp_val_q;
    if (stop_exit && stp_arm_q) begin
      cap_d     = stp_val_q;
      stp_arm_d = 1'h0;
    end else if (cap_edge && !stop_mode && !cap_inh_q) begin
      cap_d = cnt_q;
    end
    if (cap_edge && stop_mode && !stp_arm_q) begin
      stp_arm_d = 1'h1;
      stp_val_d = cnt_q;
    end

    // compare pin follows output level on match
    pin_d = set_ev[`CCT_EV_CMP] ? compare_output_level_q : compare_pin;

    // register reads and their side effects
    en_d       = en_q;
    edge_d     = edge_q;
    compare_output_level_d     = compare_output_level_q;
    arm_d      = arm_q;
    clr_ev     = 3'h0;
    cnt_lat_d  = cnt_lat_q;
    cnt_hold_d = cnt_hold_q;
    alt_lat_d  = alt_lat_q;
    alt_hold_d = alt_hold_q;
    cap_inh_d  = cap_inh_q;
    cmp_d      = cmp_q;
    cmp_inh_d  = cmp_inh_q;
    evt_msk_d  = evt_msk_q;
    rval       = 8'h0;
    mapped     = 1'h1;
    if (cct_hit(paddr, `CCT_IDX_CTRL)) begin
      rval = {en_q, 3'h0, edge_q, compare_output_level_q};
    end else if (cct_hit(paddr, `CCT_IDX_STAT)) begin
      rval = {flags_q, 5'h0};
      if (rd_go) begin
        arm_d = arm_q | flags_q;
      end
    end else if (cct_hit(paddr, `CCT_IDX_CAPH)) begin
      rval = cap_q[15:8];
      if (rd_go) begin
        cap_inh_d = 1'h1;
      end
    end else if (cct_hit(paddr, `CCT_IDX_CAPL)) begin
      rval = cap_q[7:0];
      if (rd_go) begin
        cap_inh_d = 1'h0;
        clr_ev[`CCT_EV_CAP] = arm_q[`CCT_EV_CAP];
      end
    end else if (cct_hit(paddr, `CCT_IDX_CMPH)) begin
      rval = cmp_q[15:8];
    end else if (cct_hit(paddr, `CCT_IDX_CMPL)) begin
      rval = cmp_q[7:0];
      if (rd_go || wr_done) begin
        clr_ev[`CCT_EV_CMP] = arm_q[`CCT_EV_CMP];
      end
    end else if (cct_hit(paddr, `CCT_IDX_CNTH)) begin
      rval = cnt_q[15:8];
      if (rd_go) begin
        cnt_hold_d = 1'h1;
        cnt_lat_d  = cnt_q[7:0];
      end
    end else if (cct_hit(paddr, `CCT_IDX_CNTL)) begin
      rval = cnt_hold_q ? cnt_lat_q : cnt_q[7:0];
      if (rd_go) begin
        cnt_hold_d = 1'h0;
        clr_ev[`CCT_EV_OVF] = arm_q[`CCT_EV_OVF];
      end
    end else if (cct_hit(paddr, `CCT_IDX_ALTH)) begin
      rval = cnt_q[15:8];
      if (rd_go) begin
        alt_hold_d = 1'h1;
        alt_lat_d  = cnt_q[7:0];
      end
    end else if (cct_hit(paddr, `CCT_IDX_ALTL)) begin
      // no overflow clear from this low byte
      rval = alt_hold_q ? alt_lat_q : cnt_q[7:0];
      if (rd_go) begin
        alt_hold_d = 1'h0;
      end
    end else if (cct_hit(paddr, `CCT_IDX_EVTS)) begin
      rval = {5'h0, evt_sts_q};
    end else if (cct_hit(paddr, `CCT_IDX_EVTM)) begin
      rval = {5'h0, evt_msk_q};
    end else begin
      mapped = 1'h0;
    end

    // writes; counter and capture pairs have no write path at all
    if (wr_done) begin
      if (cct_hit(paddr, `CCT_IDX_CTRL)) begin
        en_d   = pwdata[`CCT_CTRL_CAPIE:`CCT_CTRL_OVFIE];
        edge_d = pwdata[`CCT_CTRL_EDGE];
        compare_output_level_d = pwdata[`CCT_CTRL_COMPARE_OUTPUT_LEVEL];
      end else if (cct_hit(paddr, `CCT_IDX_CMPH)) begin
        cmp_d[15:8] = pwdata[7:0];
        cmp_inh_d   = 1'h1;
      end else if (cct_hit(paddr, `CCT_IDX_CMPL)) begin
        cmp_d[7:0] = pwdata[7:0];
        cmp_inh_d  = 1'h0;
      end else if (cct_hit(paddr, `CCT_IDX_EVTM)) begin
        evt_msk_d = pwdata[2:0];
      end
    end

    // arming ends with the clearing access, set beats clear
    arm_d   = arm_d & ~clr_ev;
    flags_d = (flags_q & ~clr_ev) | set_ev;
    evt_sts_d = evt_sts_q;
    if (wr_done && cct_hit(paddr, `CCT_IDX_EVTS)) begin
      evt_sts_d = evt_sts_q & ~pwdata[2:0];
    end
    evt_sts_d = evt_sts_d | set_ev;

    irq_d  = |(flags_q & en_q) || |(evt_sts_q & evt_msk_q);
    wake_d = irq_d && wait_mode;

    // one wait state: answer in the second access cycle
    pready_d  = acc;
    pslverr_d = acc && !mapped;
    prdata_d  = (acc && !pwrite && mapped) ? {24'h0, rval} : prdata;
  end

  // cleared by power-on only, ordinary resets leave them alone
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      flags_q <= 3'h0;
      edge_q  <= 1'h0;
      cap_q   <= 16'h0;
      cmp_q   <= 16'h0;
    end else begin
      flags_q <= flags_d;
      edge_q  <= edge_d;
      cap_q   <= cap_d;
      cmp_q   <= cmp_d;
    end
  end

  always_ff @(posedge pclk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      cap_prev_q  <= 1'h0;
      en_q        <= 3'h0;
      compare_output_level_q      <= 1'h0;
      arm_q       <= 3'h0;
      cnt_q       <= `CCT_CNT_RESET;
      cnt_lat_q   <= 8'h0;
      cnt_hold_q  <= 1'h0;
      alt_lat_q   <= 8'h0;
      alt_hold_q  <= 1'h0;
      cap_inh_q   <= 1'h0;
      cmp_inh_q   <= 1'h0;
      stop_q      <= 1'h0;
      stp_arm_q   <= 1'h0;
      stp_val_q   <= 16'h0;
      compare_pin <= 1'h0;
      evt_sts_q   <= 3'h0;
      evt_msk_q   <= 3'h0;
      irq         <= 1'h0;
      wake        <= 1'h0;
      pready      <= 1'h0;
      pslverr     <= 1'h0;
      prdata      <= 32'h0;
    end else begin
      cap_prev_q  <= cap_prev_d;
      en_q        <= en_d;
      compare_output_level_q      <= compare_output_level_d;
      arm_q       <= arm_d;
      cnt_q       <= cnt_d;
      cnt_lat_q   <= cnt_lat_d;
      cnt_hold_q  <= cnt_hold_d;
      alt_lat_q   <= alt_lat_d;
      alt_hold_q  <= alt_hold_d;
      cap_inh_q   <= cap_inh_d;
      cmp_inh_q   <= cmp_inh_d;
      stop_q      <= stop_d;
      stp_arm_q   <= stp_arm_d;
      stp_val_q   <= stp_val_d;
      compare_pin <= pin_d;
      evt_sts_q   <= evt_sts_d;
      evt_msk_q   <= evt_msk_d;
      irq         <= irq_d;
      wake        <= wake_d;
      pready      <= pready_d;
      pslverr     <= pslverr_d;
      prdata      <= prdata_d;
    end
  end

  AST_PRESCALE: assert property (@(posedge pclk) disable iff (!rst_all_n)
    tick |=> !tick [*3] ##1 tick)
    else $error("prescaler tick spacing is not four clocks");

  AST_CNT_STEP: assert property (@(posedge pclk) disable iff (!rst_all_n)
    (tick && !stop_mode) |=> cnt_q == $past(cnt_q) + 16'h1)
    else $error("counter did not advance on tick");

  AST_STOP_HOLD: assert property (@(posedge pclk) disable iff (!rst_all_n)
    stop_mode |=> cnt_q == $past(cnt_q))
    else $error("counter moved during stop");

  AST_OVF_SET: assert property (@(posedge pclk) disable iff (!rst_all_n)
    (tick && !stop_mode && cnt_q == `CCT_CNT_MAX) |=> flags_q[`CCT_EV_OVF] && cnt_q == 16'h0)
    else $error("wrap did not raise overflow flag");

  AST_PIN_LEVEL: assert property (@(posedge pclk) disable iff (!rst_all_n)
    (tick && !stop_mode && !cmp_inh_q && cnt_q == cmp_q)
      |=> compare_pin == $past(compare_output_level_q) && flags_q[`CCT_EV_CMP])
    else $error("match did not drive output level");

  AST_CMP_INH: assert property (@(posedge pclk) disable iff (!rst_all_n)
    (wr_done && cct_hit(paddr, `CCT_IDX_CMPH))
      ##1 (!flags_q[`CCT_EV_CMP] && !clr_ev[`CCT_EV_CMP])
      |=> !flags_q[`CCT_EV_CMP])
    else $error("compare matched while inhibited");

  AST_CAP_INH: assert property (@(posedge pclk) disable iff (!rst_all_n)
    (cap_inh_q && !stop_exit) |=> cap_q == $past(cap_q))
    else $error("capture pair changed while inhibited");

  AST_CAP_TAKE: assert property (@(posedge pclk) disable iff (!rst_all_n)
    (cap_edge && !stop_mode && !cap_inh_q && !stop_exit)
      |=> cap_q == $past(cnt_q) && flags_q[`CCT_EV_CAP])
    else $error("selected edge did not capture counter");

  AST_STOP_SILENT: assert property (@(posedge pclk) disable iff (!rst_all_n)
    (stop_mode && stop_q && !flags_q[`CCT_EV_CAP]) |=> !flags_q[`CCT_EV_CAP])
    else $error("capture flag set during stop");

  AST_IRQ: assert property (@(posedge pclk) disable iff (!rst_all_n)
    |(flags_q & en_q) |=> irq)
    else $error("enabled flag raised no interrupt");

  AST_OVF_KEEP: assert property (@(posedge pclk) disable iff (!rst_all_n)
    (flags_q[`CCT_EV_OVF] && !(rd_go && cct_hit(paddr, `CCT_IDX_CNTL)))
      |=> flags_q[`CCT_EV_OVF])
    else $error("overflow flag lost without counter low read");

  AST_CAP_KEEP: assert property (@(posedge pclk) disable iff (!rst_all_n)
    (flags_q[`CCT_EV_CAP] && !(rd_go && cct_hit(paddr, `CCT_IDX_CAPL)))
      |=> flags_q[`CCT_EV_CAP])
    else $error("capture flag lost without capture low read");

  AST_CNT_FREEZE: assert property (@(posedge pclk) disable iff (!rst_all_n)
    (cnt_hold_q && !(rd_go && cct_hit(paddr, `CCT_IDX_CNTH)))
      |=> cnt_lat_q == $past(cnt_lat_q))
    else $error("latched counter low byte moved");

  AST_WAKE_IRQ: assert property (@(posedge pclk) disable iff (!rst_all_n)
    (irq_d && wait_mode) |=> wake)
    else $error("enabled interrupt did not wake");
endmodule : cct_timer
`default_nettype wire

// >>> cct_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module cct_pin_model (
  input  wire logic       pclk,
  input  wire logic       lvl_req,
  input  wire logic [3:0] dly,
  output var  logic       capture_pin
);
  // requested level reaches the pin dly+1 clocks late, like a slow source
  logic [3:0] cnt_q;
  initial begin
    capture_pin = 1'b0;
    cnt_q = 4'h0;
  end
  always @(posedge pclk) begin
    if (lvl_req == capture_pin) begin
      cnt_q <= 4'h0;
    end else if (cnt_q >= dly) begin
      capture_pin <= lvl_req;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : cct_pin_model
`default_nettype wire

// >>> test_capture_compare_timer_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "cct_timer_regs.svh"
module test_capture_compare_timer_regs
  import cct_pkg::*;
;
  logic        pclk, presetn, por_n, psel, penable, pwrite;
  logic        wait_mode, stop_mode, lvl_req, err;
  logic        pready, pslverr, capture_pin, compare_pin, irq, wake;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  dly;
  logic [15:0] a, b;
  int          fail_count, check_count, cyc;

  cct_timer uut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
    .compare_pin(compare_pin), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .irq(irq), .wake(wake));
  cct_pin_model pin (.pclk(pclk), .lvl_req(lvl_req), .dly(dly),
    .capture_pin(capture_pin));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // tests should need about 600 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  // request held until pready is sampled high
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rr(input logic [5:0] idx);
    apb(1'b0, idx, 8'h00);
  endtask : rr

  task automatic t_reset();
    rr(`CCT_IDX_STAT);
    rr(`CCT_IDX_CNTL);
    apb(1'b1, `CCT_IDX_CTRL, 8'hE3);
    rr(`CCT_IDX_CTRL);
    chk("ctrl rw", 32'hE3, rd);
    @(posedge pclk);
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    rr(`CCT_IDX_CTRL);
    chk("ctrl after reset", 32'h02, rd);
    rr(`CCT_IDX_CNTH);
    chk("count after reset", 32'hFF, rd);
    idle(30);
    rr(`CCT_IDX_STAT);
    chk("overflow flag", 32'h60, rd);
    apb(1'b1, `CCT_IDX_CTRL, 8'h20);
    idle(2);
    chk("irq overflow", 32'h1, irq);
    wait_mode <= 1'b1;
    idle(2);
    chk("wake", 32'h1, wake);
    wait_mode <= 1'b0;
    rr(`CCT_IDX_ALTL);
    rr(`CCT_IDX_STAT);
    chk("alt keeps flag", 32'h60, rd);
    rr(`CCT_IDX_CNTL);
    rr(`CCT_IDX_STAT);
    chk("overflow cleared", 32'h40, rd);
    chk("irq low", 32'h0, irq);
    rr(`CCT_IDX_CMPL);
  endtask : t_reset

  task automatic t_latch();
    rr(`CCT_IDX_CNTH);
    a[15:8] = rd[7:0];
    idle(40);
    rr(`CCT_IDX_CNTL);
    a[7:0] = rd[7:0];
    rr(`CCT_IDX_ALTH);
    b[15:8] = rd[7:0];
    rr(`CCT_IDX_ALTL);
    b[7:0] = rd[7:0];
    chk("low byte frozen", 32'h1, 32'(b - a >= 10 && b - a <= 30));
    apb(1'b1, `CCT_IDX_CNTH, 8'hAA);
    apb(1'b1, `CCT_IDX_ALTH, 8'hAA);
    rr(`CCT_IDX_CNTH);
    chk("counter write", 32'h00, rd);
  endtask : t_latch

  task automatic t_capture();
    apb(1'b1, `CCT_IDX_CTRL, 8'h82);
    lvl_req <= 1'b1;
    idle(10);
    rr(`CCT_IDX_STAT);
    chk("capture flag", 32'h80, rd);
    chk("irq capture", 32'h1, irq);
    rr(`CCT_IDX_CAPH);
    a[15:8] = rd[7:0];
    rr(`CCT_IDX_CAPL);
    a[7:0] = rd[7:0];
    rr(`CCT_IDX_CNTH);
    b[15:8] = rd[7:0];
    rr(`CCT_IDX_CNTL);
    b[7:0] = rd[7:0];
    chk("captured count", 32'h1, 32'(b - a >= 1 && b - a <= 15));
    rr(`CCT_IDX_STAT);
    chk("capture cleared", 32'h00, rd);
    lvl_req <= 1'b0;
    idle(10);
    rr(`CCT_IDX_STAT);
    chk("falling ignored", 32'h00, rd);
    rr(`CCT_IDX_CAPH);
    lvl_req <= 1'b1;
    idle(10);
    rr(`CCT_IDX_CAPL);
    chk("capture inhibited", {24'h0, a[7:0]}, rd);
    apb(1'b1, `CCT_IDX_CAPL, 8'h55);
    rr(`CCT_IDX_CAPL);
    chk("capture write", {24'h0, a[7:0]}, rd);
  endtask : t_capture

  task automatic t_compare();
    apb(1'b1, `CCT_IDX_CTRL, 8'h01);
    rr(`CCT_IDX_CNTH);
    a[15:8] = rd[7:0];
    rr(`CCT_IDX_CNTL);
    a[7:0] = rd[7:0];
    a = a + 16'h0014;
    apb(1'b1, `CCT_IDX_CMPH, a[15:8]);
    rr(`CCT_IDX_STAT);
    apb(1'b1, `CCT_IDX_CMPL, a[7:0]);
    apb(1'b1, `CCT_IDX_CTRL, 8'h41);
    chk("pin before match", 32'h0, compare_pin);
    idle(100);
    chk("pin at match", 32'h1, compare_pin);
    rr(`CCT_IDX_STAT);
    chk("compare flag", 32'hC0, rd);
    rr(`CCT_IDX_CMPL);
    chk("compare low", {24'h0, a[7:0]}, rd);
    rr(`CCT_IDX_STAT);
    chk("compare cleared", 32'h80, rd);
  endtask : t_compare

  task automatic t_events();
    apb(1'b1, `CCT_IDX_CTRL, 8'h00);
    rr(`CCT_IDX_EVTS);
    chk("event status", 32'h7, rd);
    chk("irq masked", 32'h0, irq);
    apb(1'b1, `CCT_IDX_EVTM, 8'h02);
    idle(2);
    chk("irq unmasked", 32'h1, irq);
    apb(1'b1, `CCT_IDX_EVTS, 8'h02);
    idle(2);
    chk("irq after clear", 32'h0, irq);
    rr(`CCT_IDX_EVTS);
    chk("event w1c", 32'h5, rd);
    rr(`CCT_IDX_EVTM);
    chk("event mask", 32'h2, rd);
    rr(6'h0F);
    chk("unmapped error", 32'h1, err);
  endtask : t_events

  task automatic t_stop();
    rr(`CCT_IDX_CAPL);
    rr(`CCT_IDX_STAT);
    chk("flags clear", 32'h00, rd);
    dly <= 4'h5;
    stop_mode <= 1'b1;
    idle(4);
    rr(`CCT_IDX_ALTH);
    rr(`CCT_IDX_ALTL);
    a = {8'h00, rd[7:0]};
    idle(40);
    rr(`CCT_IDX_ALTH);
    rr(`CCT_IDX_ALTL);
    chk("stopped count", {24'h0, a[7:0]}, rd);
    lvl_req <= 1'b0;
    idle(12);
    rr(`CCT_IDX_STAT);
    chk("silent in stop", 32'h00, rd);
    stop_mode <= 1'b0;
    idle(10);
    rr(`CCT_IDX_STAT);
    chk("capture on exit", 32'h80, rd);
    rr(`CCT_IDX_CAPL);
    chk("capture data on exit", {24'h0, a[7:0]}, rd);
    // leave stop through reset with an armed edge: nothing may survive
    lvl_req <= 1'b1;
    idle(12);
    stop_mode <= 1'b1;
    lvl_req <= 1'b0;
    idle(12);
    presetn <= 1'b0;
    stop_mode <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    rr(`CCT_IDX_STAT);
    chk("reset exit drops capture", 32'h00, rd);
    rr(`CCT_IDX_CNTH);
    chk("reset exit count", 32'hFF, rd);
  endtask : t_stop

  initial begin
    cyc = 0;
    fail_count = 0;
    check_count = 0;
    por_n = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wait_mode = 1'b0;
    stop_mode = 1'b0;
    lvl_req = 1'b0;
    dly = 4'h0;
    repeat (20) @(posedge pclk);
    por_n <= 1'b1;
    presetn <= 1'b1;
    idle(30);
    t_reset();
    t_latch();
    t_capture();
    t_compare();
    t_events();
    t_stop();
    wrap_up();
  end
endmodule : test_capture_compare_timer_regs
`default_nettype wire
